/* File: logic/sfc_pkg.sv */
package sfc_pkg;
   // ------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_LINE_STATUS = 8'h00;
   localparam logic [7:0] ADDR_BIT_ORDER = 8'h04;
   localparam logic [7:0] ADDR_THRESHOLD = 8'h08;
   localparam logic [7:0] ADDR_MODE = 8'h0c;
   localparam logic [7:0] ADDR_FIFO_CTRL = 8'h10;
   localparam logic [7:0] ADDR_COUNTS = 8'h14;
   // ------------------------------------------------------------
   // Reset values and fixed bits
   // ------------------------------------------------------------
   localparam logic [7:0] BIT_ORDER_FIXED = 8'hf2;
   localparam logic [4:0] THR_COUNT_RST = 5'h1f;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int BO_DIR = 3;
   localparam int TH_RSEL = 15;
   localparam int TH_RCNT = 8;
   localparam int TH_TSEL = 7;
   localparam int MD_SYNC = 7;
   localparam int MD_CHR = 6;
   localparam int MD_PE = 5;
   localparam int MD_STOP = 3;
   localparam int MD_CKE = 0;
   localparam int FC_RCODE = 6;
   localparam int FC_TCODE = 4;
   // ------------------------------------------------------------
   // Sizes and threshold tables
   // ------------------------------------------------------------
   localparam int FIFO_DEPTH = 16;
   localparam logic [4:0] FIFO_FULL = 5'h10;
   localparam logic [4:0] RX_ASYNC_TAB [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
   localparam logic [4:0] RX_SYNC_TAB [4] = '{5'h01, 5'h02, 5'h08, 5'h0e};
   localparam logic [4:0] TX_CODE_TAB [4] = '{5'h08, 5'h04, 5'h02, 5'h00};
   localparam logic [7:0] CHAR_MASK7 = 8'h7f;
   typedef enum logic [1:0] {
      CK_INT = 2'b00,
      CK_INT_OUT = 2'b01,
      CK_EXT = 2'b10,
      CK_BAD = 2'b11
   } clk_src_type;
endpackage : sfc_pkg

/* File: logic/serial_fifo_trigger_format_ctrl.sv */
`timescale 1ns/1ps
// Operation
// R1: Overrun flag ignores writes of one; zero clears only after it was read as one.
// R2: Set overrun when a character completes with sixteen bytes unread.
// R3: On overrun keep FIFO, drop new character, block reception while flagged.
// R4: Receiver disable leaves overrun alone; reset or read-then-zero clears it.
// R5: Line status resets to zero; upper fifteen bits read zero.
// R6: Bit-order bit: zero LSB first, one MSB first, both directions.
// R7: Bit order applies only with 8-bit characters, in both modes.
// R8: Receive select: zero uses coded field, one uses direct count.
// R9: Direct receive: flag when stored count reaches value 1..16.
// R10: Software must not program receive count 0 or 17..31.
// R11: Transmit select: zero uses coded field, one uses direct count.
// R12: Direct transmit: flag when untransmitted count reaches value 0..15.
// R13: Separate sixteen-entry transmit and receive FIFOs.
// R14: Async: length bit 8/7 data, parity enable, stop bits 1 or 2.
// R15: Sync mode: fixed 8 bits, no parity, no stop bits.
// R16: Async reception reports framing, parity, full, overrun, ready, break.
// R17: Sync reception reports overrun only. The code also still drives ready and the receive full flag in sync mode.
// R18: Async clock codes: 00 internal, 01 drive 16x out, 10 external, 11 bad.
// R19: Sync: upper bit clear drives clock out, set takes pin as input.
// R20: External async clock must be sixteen times the bit rate.
// R21: Coded receive: 1,4,8,14 async; 1,2,8,14 sync.
// R22: Coded transmit: flag when count below 8,4,2,0.
// R23: Armed state set by reading overrun as one enables the zero clear.
// R24: Thresholds are compared every clock so changes act at once.
module serial_fifo_trigger_format_ctrl
   import sfc_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Receive engine side
   input wire logic i_rx_done,
   input wire logic [7:0] i_rx_char,
   input wire logic i_rx_frame_err,
   input wire logic i_rx_parity_err,
   input wire logic i_rx_break,
   input wire logic i_receiver_enable,
   output logic o_rx_accept_en,
   output logic o_rx_full_flag,
   output logic o_rx_ready,
   output logic o_rx_err_frame,
   output logic o_rx_err_parity,
   output logic o_rx_break,
   output logic o_overrun_flag,
   // Transmit engine side
   input wire logic i_tx_take,
   output logic [7:0] o_tx_char,
   output logic o_tx_avail,
   output logic o_tx_low_flag,
   // Format and clock decode
   output logic o_msb_first,
   output logic o_seven_bit,
   output logic o_parity_on,
   output logic o_two_stop,
   output logic o_sync_mode,
   output logic o_clk_external,
   output logic o_clk_drive_out,
   output logic o_clk_pin_port,
   output logic o_clk_bad_setting
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic overrun_ff, armed_ff, msb_ff, rx_pick_ff;
   logic rsel_ff, tsel_ff;
   logic [4:0] rcnt_ff, tcnt_ff;
   logic [7:0] mode_ff;
   logic [1:0] rcode_ff, tcode_ff;
   logic [7:0] rx_mem [FIFO_DEPTH];
   logic [7:0] tx_mem [FIFO_DEPTH];
   logic [3:0] rx_wp_ff, rx_rp_ff, tx_wp_ff, tx_rp_ff;
   logic [4:0] rx_n_ff, tx_n_ff;
   logic [3:0] rx_err_ff;

   function automatic logic [7:0] reverse8(input logic [7:0] v);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[i] = v[7 - i];
      end
      return r;
   endfunction : reverse8

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire acc = i_psel && i_penable;
   wire wr = acc && i_pwrite;
   wire rd = acc && !i_pwrite;
   wire hit_ls = i_paddr == ADDR_LINE_STATUS;
   wire hit_bo = i_paddr == ADDR_BIT_ORDER;
   wire hit_th = i_paddr == ADDR_THRESHOLD;
   wire hit_md = i_paddr == ADDR_MODE;
   wire hit_fc = i_paddr == ADDR_FIFO_CTRL;
   wire hit_cn = i_paddr == ADDR_COUNTS;
   wire hit_any = hit_ls | hit_bo | hit_th | hit_md | hit_fc | hit_cn;
   wire [15:0] th_word = {rsel_ff, 2'b00, rcnt_ff, tsel_ff, 2'b00, tcnt_ff};
   wire [7:0] fc_word = {rcode_ff, tcode_ff, 4'h0};
   wire [7:0] bo_word = BIT_ORDER_FIXED | ({7'h00, msb_ff} << BO_DIR);
   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h0;
      if (hit_ls) rdata = {31'h0, overrun_ff}; // R5
      if (hit_bo) rdata = {24'h0, bo_word};
      if (hit_th) rdata = {16'h0, th_word};
      if (hit_md) rdata = {24'h0, mode_ff};
      if (hit_fc) rdata = {24'h0, fc_word};
      if (hit_cn) rdata = {19'h0, tx_n_ff, 3'h0, rx_n_ff};
   end

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   wire sync_m = mode_ff[MD_SYNC];
   wire seven = !sync_m && mode_ff[MD_CHR]; // R14 R15
   wire [1:0] cke = mode_ff[MD_CKE +: 2];
   wire msb_eff = msb_ff && !seven; // R6 R7

   // ------------------------------------------------------------
   // Receive path
   // ------------------------------------------------------------
   wire rx_full = rx_n_ff == FIFO_FULL;
   wire rx_ovr = i_rx_done && rx_full && !overrun_ff; // R2
   wire rx_push = i_rx_done && !rx_full && !overrun_ff; // R3
   wire rx_pop = rd && hit_fc && rx_pick_ff;
   wire rd_setup = i_psel && !i_penable && !i_pwrite;
   wire [31:0] rd_word = (hit_fc && rx_n_ff != 5'h00) ?
      {24'h0, rx_mem[rx_rp_ff]} : rdata;
   wire [7:0] rx_masked = seven ? (i_rx_char & CHAR_MASK7) : i_rx_char;
   wire [7:0] rx_store = msb_eff ? reverse8(rx_masked) : rx_masked;
   wire [4:0] rx_thr = rsel_ff ? rcnt_ff :
      (sync_m ? RX_SYNC_TAB[rcode_ff] : RX_ASYNC_TAB[rcode_ff]); // R8 R21
   wire [4:0] tx_thr = tsel_ff ? tcnt_ff : TX_CODE_TAB[tcode_ff]; // R11
   wire ov_clear = wr && hit_ls && !i_pwdata[0] && armed_ff; // R1 R23

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         overrun_ff <= 1'b0;
         armed_ff <= 1'b0;
      end else begin
         // Set wins over clear; i_receiver_enable is not looked at. R4
         if (rx_ovr) begin
            overrun_ff <= 1'b1;
         end else if (ov_clear) begin
            overrun_ff <= 1'b0;
         end
         // Armed only when the word handed to software showed the flag.
         if (rd && hit_ls && o_prdata[0]) begin
            armed_ff <= 1'b1; // R23
         end else if (ov_clear || rx_ovr) begin
            armed_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_wp_ff <= 4'h0;
         rx_rp_ff <= 4'h0;
         rx_n_ff <= 5'h00;
         rx_err_ff <= 4'h0;
         o_prdata <= 32'h0;
         rx_pick_ff <= 1'b0;
      end else begin
         if (rx_push) begin
            rx_mem[rx_wp_ff] <= rx_store; // R13
            rx_wp_ff <= rx_wp_ff + 4'h1;
            // Framing, parity and break are not reported in synchronous mode; ready and full still are. R16 R17
            rx_err_ff <= sync_m ? 4'h0 :
               {i_rx_frame_err, i_rx_parity_err, i_rx_break, 1'b0};
         end
         if (rx_pop) rx_rp_ff <= rx_rp_ff + 4'h1;
         if (rx_push && !rx_pop) rx_n_ff <= rx_n_ff + 5'h01;
         if (!rx_push && rx_pop) rx_n_ff <= rx_n_ff - 5'h01;
         // Read data is latched at the setup edge so that it stands in the
         // access cycle; the FIFO pop waits for the access edge.
         if (rd_setup) o_prdata <= rd_word;
         rx_pick_ff <= rd_setup && hit_fc && rx_n_ff != 5'h00;
      end
   end

   // ------------------------------------------------------------
   // Transmit path
   // ------------------------------------------------------------
   wire tx_push = wr && hit_cn && tx_n_ff != FIFO_FULL;
   wire tx_pop = i_tx_take && tx_n_ff != 5'h00;
   wire [7:0] tx_in = seven ? (i_pwdata[7:0] & CHAR_MASK7) : i_pwdata[7:0];

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         tx_wp_ff <= 4'h0;
         tx_rp_ff <= 4'h0;
         tx_n_ff <= 5'h00;
      end else begin
         if (tx_push) begin
            tx_mem[tx_wp_ff] <= msb_eff ? reverse8(tx_in) : tx_in; // R6
            tx_wp_ff <= tx_wp_ff + 4'h1;
         end
         if (tx_pop) tx_rp_ff <= tx_rp_ff + 4'h1;
         if (tx_push && !tx_pop) tx_n_ff <= tx_n_ff + 5'h01;
         if (!tx_push && tx_pop) tx_n_ff <= tx_n_ff - 5'h01;
      end
   end

   // ------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         msb_ff <= 1'b0;
         rsel_ff <= 1'b0;
         tsel_ff <= 1'b0;
         rcnt_ff <= THR_COUNT_RST;
         tcnt_ff <= THR_COUNT_RST;
         mode_ff <= 8'h00;
         rcode_ff <= 2'b00;
         tcode_ff <= 2'b00;
      end else if (wr) begin
         if (hit_bo) msb_ff <= i_pwdata[BO_DIR];
         if (hit_th) begin
            rsel_ff <= i_pwdata[TH_RSEL];
            rcnt_ff <= i_pwdata[TH_RCNT +: 5];
            tsel_ff <= i_pwdata[TH_TSEL];
            tcnt_ff <= i_pwdata[4:0];
         end
         if (hit_md) mode_ff <= i_pwdata[7:0];
         if (hit_fc) begin
            rcode_ff <= i_pwdata[FC_RCODE +: 2];
            tcode_ff <= i_pwdata[FC_TCODE +: 2];
         end
      end
   end

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_rx_accept_en <= 1'b0;
         o_rx_full_flag <= 1'b0;
         o_rx_ready <= 1'b0;
         o_rx_err_frame <= 1'b0;
         o_rx_err_parity <= 1'b0;
         o_rx_break <= 1'b0;
         o_overrun_flag <= 1'b0;
         o_tx_char <= 8'h00;
         o_tx_avail <= 1'b0;
         o_tx_low_flag <= 1'b0;
         o_msb_first <= 1'b0;
         o_seven_bit <= 1'b0;
         o_parity_on <= 1'b0;
         o_two_stop <= 1'b0;
         o_sync_mode <= 1'b0;
         o_clk_external <= 1'b0;
         o_clk_drive_out <= 1'b0;
         o_clk_pin_port <= 1'b1;
         o_clk_bad_setting <= 1'b0;
      end else begin
         o_pready <= i_psel && !i_penable;
         o_pslverr <= i_psel && !i_penable && !hit_any;
         o_rx_accept_en <= i_receiver_enable && !overrun_ff; // R3
         o_rx_full_flag <= rx_n_ff >= rx_thr; // R9 R24
         o_rx_ready <= rx_n_ff != 5'h00;
         o_rx_err_frame <= rx_err_ff[3];
         o_rx_err_parity <= rx_err_ff[2];
         o_rx_break <= rx_err_ff[1];
         o_overrun_flag <= overrun_ff;
         o_tx_char <= tx_mem[tx_rp_ff];
         o_tx_avail <= tx_n_ff != 5'h00;
         // Direct count flags on reaching; coded flags below. R12 R22
         o_tx_low_flag <= tsel_ff ? (tx_n_ff <= tx_thr) : (tx_n_ff < tx_thr);
         o_msb_first <= msb_eff;
         o_seven_bit <= seven;
         o_parity_on <= !sync_m && mode_ff[MD_PE]; // R14 R15
         o_two_stop <= !sync_m && mode_ff[MD_STOP];
         o_sync_mode <= sync_m;
         o_clk_external <= sync_m ? cke[1] : (cke == CK_EXT); // R18 R19
         o_clk_drive_out <= sync_m ? !cke[1] : (cke == CK_INT_OUT);
         o_clk_pin_port <= !sync_m && cke == CK_INT;
         o_clk_bad_setting <= !sync_m && cke == CK_BAD;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   ovr_no_set1_a: assert property (@(posedge i_clk) disable iff (i_rst) // R1
      !overrun_ff && !rx_ovr |=> !overrun_ff)
      else $error("overrun set without cause");
   ovr_set_a: assert property (@(posedge i_clk) disable iff (i_rst) // R2
      rx_ovr |=> overrun_ff && o_overrun_flag == 1'b0 ##1 o_overrun_flag)
      else $error("overrun not raised");
   ovr_hold_fifo_a: assert property (@(posedge i_clk) disable iff (i_rst) // R3
      overrun_ff && !rx_pop |=> rx_n_ff == $past(rx_n_ff))
      else $error("fifo changed during overrun");
   ovr_keep_a: assert property (@(posedge i_clk) disable iff (i_rst) // R4
      overrun_ff && !ov_clear |=> overrun_ff)
      else $error("overrun lost");
   ovr_clear_a: assert property (@(posedge i_clk) disable iff (i_rst) // R23
      ov_clear && !rx_ovr |=> !overrun_ff ##1 !o_overrun_flag)
      else $error("overrun not cleared");
   rx_thr_a: assert property (@(posedge i_clk) disable iff (i_rst) // R9
      rsel_ff && rx_n_ff >= rcnt_ff |=> o_rx_full_flag)
      else $error("rx full flag missing");
   tx_thr_a: assert property (@(posedge i_clk) disable iff (i_rst) // R22
      !tsel_ff && tx_n_ff < TX_CODE_TAB[tcode_ff] |=> o_tx_low_flag)
      else $error("tx low flag missing");
   sync_fmt_a: assert property (@(posedge i_clk) disable iff (i_rst) // R15
      sync_m |=> !o_seven_bit && !o_parity_on && !o_two_stop)
      else $error("sync format wrong");
   fifo_cap_a: assert property (@(posedge i_clk) disable iff (i_rst) // R13
      rx_n_ff <= FIFO_FULL && tx_n_ff <= FIFO_FULL)
      else $error("fifo count over depth");
   pready_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_psel && !i_penable |=> o_pready)
      else $error("ready missing in access cycle");
   slverr_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_psel && !i_penable && !hit_any |=> o_pslverr)
      else $error("unmapped access not refused");
   ls_upper_a: assert property (@(posedge i_clk) disable iff (i_rst) // R5
      rd_setup && hit_ls |=> o_prdata[31:1] == 31'h0)
      else $error("line status upper bits set");
   order_len_a: assert property (@(posedge i_clk) disable iff (i_rst) // R7
      seven |=> !o_msb_first)
      else $error("bit order applied to short chars");
   tx_order_a: assert property (@(posedge i_clk) disable iff (i_rst) // R6
      msb_eff && tx_push |=>
      tx_mem[$past(tx_wp_ff)] == reverse8($past(tx_in)))
      else $error("tx byte not reversed");
   tx_direct_a: assert property (@(posedge i_clk) disable iff (i_rst) // R12
      tsel_ff && tx_n_ff <= tcnt_ff |=> o_tx_low_flag)
      else $error("tx direct flag missing");
   tx_sel_a: assert property (@(posedge i_clk) disable iff (i_rst) // R11
      tsel_ff && tx_n_ff > tcnt_ff |=> !o_tx_low_flag)
      else $error("tx direct flag early");
   parity_a: assert property (@(posedge i_clk) disable iff (i_rst) // R14
      !sync_m && mode_ff[MD_PE] |=> o_parity_on)
      else $error("parity enable lost");
   frame_err_a: assert property (@(posedge i_clk) disable iff (i_rst) // R16
      rx_push && !sync_m && i_rx_frame_err |-> ##2 o_rx_err_frame)
      else $error("framing error not reported");
   sync_err_a: assert property (@(posedge i_clk) disable iff (i_rst) // R17
      rx_push && sync_m |=> rx_err_ff == 4'h0)
      else $error("error kept in sync mode");
   clk_bad_a: assert property (@(posedge i_clk) disable iff (i_rst) // R18
      !sync_m && cke == CK_BAD |=> o_clk_bad_setting)
      else $error("forbidden clock code not flagged");
   sync_clk_a: assert property (@(posedge i_clk) disable iff (i_rst) // R19
      sync_m && !cke[1] |=> o_clk_drive_out && !o_clk_external)
      else $error("sync clock not driven");
   rx_coded_a: assert property (@(posedge i_clk) disable iff (i_rst) // R21
      !rsel_ff && !sync_m && rx_n_ff >= RX_ASYNC_TAB[rcode_ff]
      |=> o_rx_full_flag)
      else $error("rx coded flag missing");
   // ------------------------------------------------------------
   // Cover points
   // ------------------------------------------------------------
   cov_ovr_c: cover property (@(posedge i_clk) rx_ovr ##[1:100] ov_clear);
   cov_full_c: cover property (@(posedge i_clk) rx_full);
   cov_sync_c: cover property (@(posedge i_clk) sync_m && rx_push);
   cov_msb_c: cover property (@(posedge i_clk) msb_eff && tx_push);
   cov_direct_c: cover property (@(posedge i_clk) rsel_ff && o_rx_full_flag);
endmodule : serial_fifo_trigger_format_ctrl

/* File: verif/serial_peer_model.sv */
`timescale 1ns/1ps
module serial_peer_model (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Transmit engine stand-in
   input wire logic i_tx_avail,
   input wire logic i_drain,
   output logic o_take,
   // Receive engine stand-in
   output logic o_done,
   output logic [7:0] o_char,
   output logic o_ferr,
   output logic o_perr,
   output logic o_brk
);
   assign o_brk = 1'b0;
   initial begin
      o_done = 1'b0;
      o_char = 8'h00;
      o_ferr = 1'b0;
      o_perr = 1'b0;
   end
   // Pops leave a gap cycle, so the FIFO also sees a slow reader.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_take <= 1'b0;
      end else begin
         o_take <= i_drain & i_tx_avail & ~o_take;
      end
   end
   // After the pulse the lines show the inverse, not a stale copy.
   task automatic send(input logic [7:0] c, input logic f, input logic p);
      @(posedge i_clk);
      o_done <= 1'b1;
      o_char <= c;
      o_ferr <= f;
      o_perr <= p;
      @(posedge i_clk);
      o_done <= 1'b0;
      o_char <= ~c;
      o_ferr <= ~f;
      o_perr <= ~p;
   endtask : send
endmodule : serial_peer_model

/* File: verif/serial_fifo_trigger_format_ctrl_test.sv */
`timescale 1ns/1ps
module serial_fifo_trigger_format_ctrl_test;
   import sfc_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, r;
   logic pready, pslverr, e, f, p;
   logic rx_en = 1'b1;
   logic drain = 1'b0;
   logic take, done, ferr, perr, brk, rxa, full, rdy, efr, epa, ebr, ovr;
   logic avail, tlow;
   logic [7:0] rch, m, c, fc, tch;
   logic [15:0] th;
   logic [8:0] dec;
   int n_errors = 0;
   int cmp_count = 0;
   integer seed = 68592;
   logic [7:0] exp_q [$];
   logic [7:0] exp_t [$];
   serial_fifo_trigger_format_ctrl i_serial_fifo_trigger_format_ctrl (
      .i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_rx_done(done), .i_rx_char(rch), .i_rx_frame_err(ferr),
      .i_rx_parity_err(perr), .i_rx_break(brk), .i_receiver_enable(rx_en),
      .o_rx_accept_en(rxa), .o_rx_full_flag(full), .o_rx_ready(rdy),
      .o_rx_err_frame(efr), .o_rx_err_parity(epa), .o_rx_break(ebr),
      .o_overrun_flag(ovr), .i_tx_take(take), .o_tx_char(tch),
      .o_tx_avail(avail), .o_tx_low_flag(tlow), .o_msb_first(dec[8]),
      .o_seven_bit(dec[7]), .o_parity_on(dec[6]), .o_two_stop(dec[5]),
      .o_sync_mode(dec[4]), .o_clk_external(dec[3]),
      .o_clk_drive_out(dec[2]), .o_clk_pin_port(dec[1]),
      .o_clk_bad_setting(dec[0]));
   serial_peer_model i_serial_peer_model (
      .i_clk(i_clk), .i_rst(i_rst), .i_tx_avail(avail), .i_drain(drain),
      .o_take(take), .o_done(done), .o_char(rch), .o_ferr(ferr),
      .o_perr(perr), .o_brk(brk));
   initial begin
      forever #20 i_clk = ~i_clk;
   end
   // ------------------------------------------------------------
   // Tasks and expectations
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : conclude
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      @(posedge i_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         n_errors++;
         conclude();
      end
      // Taken at the very edge at which pready is seen high.
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   function automatic logic [8:0] dec_exp(input logic [7:0] md);
      if (md[7]) return {4'b1000, 1'b1, md[1], ~md[1], 2'b00};
      return {~md[6], md[6], md[5], md[3], 1'b0, md[1:0] == 2'd2,
         md[1:0] == 2'd1, md[1:0] == 2'd0, md[1:0] == 2'd3};
   endfunction : dec_exp
   function automatic logic [7:0] store_exp(input logic [7:0] ch,
      input logic [7:0] md);
      if (!md[7] && md[6]) return ch & 8'h7f;
      return {<<{ch}};
   endfunction : store_exp
   function automatic logic rx_exp(input int k, input logic s);
      if (th[15]) return k >= th[12:8];
      return k >= (s ? RX_SYNC_TAB[fc[7:6]] : RX_ASYNC_TAB[fc[7:6]]);
   endfunction : rx_exp
   function automatic logic tx_exp(input int k);
      if (th[7]) return k <= th[4:0];
      return k < TX_CODE_TAB[fc[5:4]];
   endfunction : tx_exp
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge i_clk);
      n_errors++;
      conclude();
   end
   initial begin
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
      apb(1'b0, ADDR_LINE_STATUS, 32'h0);
      chk(r, 32'h0);
      apb(1'b0, ADDR_THRESHOLD, 32'h0);
      chk(r, 32'h1f1f);
      apb(1'b0, 8'h18, 32'h0);
      chk(r, 32'h0);
      chk({31'h0, e}, 32'h1);
      apb(1'b1, ADDR_BIT_ORDER, 32'h8);
      apb(1'b0, ADDR_BIT_ORDER, 32'h0);
      chk(r, 32'hfa);
      for (int k = 1; k <= 16; k++) begin
         m = 8'($random(seed)) & 8'heb;
         th = 16'($random(seed)) & 16'h809f;
         th[4] = 1'b0;
         th[12:8] = 5'd1 + 5'({$random(seed)} % 16);
         fc = 8'($random(seed)) & 8'hf0;
         c = 8'($random(seed));
         f = 1'($random(seed));
         p = 1'($random(seed));
         apb(1'b1, ADDR_MODE, {24'h0, m});
         apb(1'b1, ADDR_THRESHOLD, {16'h0, th});
         apb(1'b1, ADDR_FIFO_CTRL, {24'h0, fc});
         apb(1'b1, ADDR_COUNTS, 32'(k));
         exp_q.push_back(store_exp(c, m));
         exp_t.push_back(store_exp(8'(k), m));
         i_serial_peer_model.send(c, f, p);
         repeat (3) @(posedge i_clk);
         chk(dec, dec_exp(m));
         chk(full, rx_exp(k, m[7]));
         chk(tlow, tx_exp(k));
         chk({efr, epa, ebr, rdy}, {f & ~m[7], p & ~m[7], 2'b01});
         apb(1'b0, ADDR_COUNTS, 32'h0);
         chk(r, (32'(k) << 8) | 32'(k));
      end
      i_serial_peer_model.send(8'h5a, 1'b0, 1'b0);
      repeat (3) @(posedge i_clk);
      chk({ovr, rxa}, 2'b10);
      apb(1'b1, ADDR_LINE_STATUS, 32'h0);
      apb(1'b1, ADDR_LINE_STATUS, 32'h1);
      rx_en <= 1'b0;
      repeat (3) @(posedge i_clk);
      chk(ovr, 1'b1);
      rx_en <= 1'b1;
      i_serial_peer_model.send(8'ha5, 1'b0, 1'b0);
      apb(1'b0, ADDR_LINE_STATUS, 32'h0);
      chk(r, 32'h1);
      apb(1'b1, ADDR_LINE_STATUS, 32'h0);
      repeat (2) @(posedge i_clk);
      chk({ovr, rxa}, 2'b01);
      for (int k = 0; k < 16; k++) begin
         apb(1'b0, ADDR_FIFO_CTRL, 32'h0);
         chk(r, {24'h0, exp_q.pop_front()});
      end
      drain <= 1'b1;
      for (int n = 0; n < 200 && avail !== 1'b0; n++) begin
         @(posedge i_clk);
         if (take === 1'b1 && exp_t.size() > 0) begin
            chk(tch, exp_t.pop_front());
         end
      end
      chk(avail, 1'b0);
      chk(32'(exp_t.size()), 32'h0);
      repeat (4) @(posedge i_clk);
      apb(1'b0, ADDR_COUNTS, 32'h0);
      chk(r, 32'h0);
      conclude();
   end
endmodule : serial_fifo_trigger_format_ctrl_test
